// ===== sls_status_bank.sv
/*
 * Sink link status register bank: audio packet status and windows, mirrors
 * of transmitter link configuration, lane training status, error counters
 * and stream attributes, read by the host over a simple read port.
 * Assumes all inputs come from link-layer logic on the same clock.
 */
// What this block does
// [RULE_01] Extension flag bit 9, cleared after nine reads
// [RULE_02] Info flag bit 0, cleared after eight reads
// [RULE_03] Bits 2:1 decoder error count, 8:3 reserved
// [RULE_04] Extension packets are fixed at 36 bytes
// [RULE_05] Nine-read keyhole, header word first, bytes ascending
// [RULE_06] Link rate mirror reads configured rate code
// [RULE_07] Lane count mirror bits 4:0, values 1-4
// [RULE_08] Framing mirror bit 0 shows enhanced framing
// [RULE_09] Training pattern mirror bits 1:0
// [RULE_10] Quality pattern mirror bits 1:0
// [RULE_11] Clock enable bit drives recovered clock test output
// [RULE_12] Scrambler off mirror bit 0
// [RULE_13] Error source select picks counted error kinds
// [RULE_14] Per-lane drive settings share one layout
// [RULE_15] Spread mirror bit 0 shows spreading on
// [RULE_16] Channel coding bit 0 defaults to one
// [RULE_17] Power state resets to power down
// [RULE_18] Lane pair status bits 0-2 and 4-6
// [RULE_19] Organisation identifier in bits 23:0
// [RULE_20] Two 15-bit counts with read-cleared valid flags
// [RULE_21] Horizontal stream attributes exposed
// [RULE_22] Vertical stream attributes exposed
// [RULE_23] Mirrors update on new value, else hold
`timescale 1ns/1ps
`include "sls_map.svh"

module sls_status_bank #(
    parameter int LANES = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Host read port
    input wire logic host_rd,
    input wire logic [11:0] host_addr,
    output logic [31:0] host_rdata,
    output logic host_rvalid,
    // Link-layer inputs
    input wire sls_pkg::sls_cfg_wr_type cfg_wr,
    input wire sls_pkg::sls_pkt_word_type pkt_word,
    input wire sls_pkg::sls_attr_type attr,
    input wire logic rs_err,
    input wire logic [LANES-1:0] lane_disp_err,
    input wire logic [LANES-1:0] lane_sym_err,
    input wire logic [3*LANES-1:0] lane_train,
    // Outputs to the link layer
    output logic info_ready,
    output logic ext_ready,
    output logic rec_clk_out_en,
    output logic [1:0] power_state
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Whether an error event counts under the selected error source
    function automatic logic err_hit(input logic [1:0] sel, input logic disp,
                                     input logic ill);
        case (sel)
            2'h0: err_hit = disp | ill;
            2'h1: err_hit = disp;
            2'h2: err_hit = ill;
            default: err_hit = 1'b0;
        endcase
    endfunction

    // Saturating increment of a lane error count
    function automatic logic [14:0] err_inc(input logic [14:0] cnt, input logic hit);
        err_inc = (hit && cnt != `SLS_ERR_MAX) ? cnt + 15'h1 : cnt;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [31:0] info_mem [0:7];       // Info packet words
    logic [31:0] ext_mem [0:8];        // Extension packet words
    logic [3:0] info_wr_q;             // Info words stored
    logic [3:0] ext_wr_q;              // Extension words stored
    logic [3:0] info_rd_q;             // Info words read
    logic [3:0] ext_rd_q;              // Keyhole read pointer
    logic info_flag_q;                 // Info packet waiting
    logic ext_flag_q;                  // Extension packet waiting
    logic [1:0] rs_cnt_q;              // Decoder error counter
    logic [7:0] rate_q;                // Link rate mirror
    logic [4:0] lanes_q;               // Lane count mirror
    logic framing_q;                   // Enhanced framing mirror
    logic [1:0] training_q;            // Training pattern mirror
    logic [1:0] quality_q;             // Quality pattern mirror
    logic rec_clk_q;                   // Recovered clock enable mirror
    logic scram_off_q;                 // Scrambler off mirror
    logic [1:0] err_src_q;             // Error source select mirror
    logic [5:0] drive_q [0:3];         // Per-lane drive settings
    logic spread_q;                    // Spread mirror
    logic coding_q;                    // Channel coding mirror
    logic [1:0] power_q;               // Requested power state
    logic [23:0] org_id_q;             // Organisation identifier
    logic [3*LANES-1:0] train_q;       // Registered lane training status
    logic [14:0] err_cnt_q [0:3];      // Lane error counts
    logic [3:0] err_vld_q;             // Lane error count valid flags
    sls_pkg::sls_attr_type attr_q;     // Latest stream attributes
    logic [31:0] rdata_q;              // Read data
    logic rvalid_q;                    // Read data valid
    logic info_ready_q;                // Info acceptance
    logic ext_ready_q;                 // Extension acceptance

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire info_rd = host_rd && host_addr >= `SLS_OFS_INFO_FIRST &&
                   host_addr <= `SLS_OFS_INFO_LAST;
    wire ext_rd = host_rd && host_addr >= `SLS_OFS_EXT_FIRST &&
                  host_addr <= `SLS_OFS_EXT_LAST;
    wire err01_rd = host_rd && host_addr == `SLS_OFS_ERR01;
    wire err23_rd = host_rd && host_addr == `SLS_OFS_ERR23;
    wire info_take = pkt_word.valid && !pkt_word.is_ext && !info_flag_q;
    wire ext_take = pkt_word.valid && pkt_word.is_ext && !ext_flag_q;
    wire info_done = info_take && info_wr_q == `SLS_INFO_WORDS - 4'h1;
    wire ext_done = ext_take && ext_wr_q == `SLS_EXT_WORDS - 4'h1;
    wire info_read_out = info_rd && info_flag_q && info_rd_q == `SLS_INFO_WORDS - 4'h1;
    wire ext_read_out = ext_rd && ext_flag_q && ext_rd_q == `SLS_EXT_WORDS - 4'h1;
    wire [3:0] err_hit_v;
    wire [3:0] err_clr_v = {err23_rd, err23_rd, err01_rd, err01_rd};
    wire [2:0] info_idx = host_addr[4:2] - 3'h1;
    wire [31:0] audio_status = {22'h0, ext_flag_q, 6'h0, rs_cnt_q, info_flag_q};

    // Per-lane counting decision
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_hit
            if (g < LANES) begin : g_on
                assign err_hit_v[g] = err_hit(err_src_q, lane_disp_err[g],
                                              lane_sym_err[g]);  // RULE_13
            end else begin : g_off
                assign err_hit_v[g] = 1'b0;
            end
        end
    endgenerate

    // Training status of lanes, missing lanes read as zero
    wire [11:0] train_all = 12'(train_q);
    wire [31:0] status01 = {25'h0, train_all[5:3], 1'b0, train_all[2:0]};   // RULE_18
    wire [31:0] status23 = {25'h0, train_all[11:9], 1'b0, train_all[8:6]};  // RULE_18

    // Read data selection
    wire [31:0] rd_mux =
        info_rd ? info_mem[info_idx] :
        ext_rd ? ext_mem[ext_rd_q] :                                        // RULE_05
        host_addr == `SLS_OFS_AUDIO_STATUS ? audio_status :                 // RULE_03
        host_addr == `SLS_OFS_LINK_RATE ? {24'h0, rate_q} :                 // RULE_06
        host_addr == `SLS_OFS_LANE_TOTAL ? {27'h0, lanes_q} :               // RULE_07
        host_addr == `SLS_OFS_FRAMING ? {31'h0, framing_q} :                // RULE_08
        host_addr == `SLS_OFS_TRAINING ? {30'h0, training_q} :              // RULE_09
        host_addr == `SLS_OFS_QUALITY ? {30'h0, quality_q} :                // RULE_10
        host_addr == `SLS_OFS_REC_CLOCK ? {31'h0, rec_clk_q} :
        host_addr == `SLS_OFS_SCRAMBLER_OFF ? {31'h0, scram_off_q} :        // RULE_12
        host_addr == `SLS_OFS_ERR_SOURCE ? {30'h0, err_src_q} :
        (host_addr >= `SLS_OFS_DRIVE_LANE0 && host_addr <= `SLS_OFS_DRIVE_LANE3) ?
            {26'h0, drive_q[host_addr[3:2]]} :                              // RULE_14
        host_addr == `SLS_OFS_SPREAD ? {31'h0, spread_q} :                  // RULE_15
        host_addr == `SLS_OFS_CODING ? {31'h0, coding_q} :
        host_addr == `SLS_OFS_POWER ? {30'h0, power_q} :
        host_addr == `SLS_OFS_STATUS01 ? status01 :
        host_addr == `SLS_OFS_STATUS23 ? status23 :
        host_addr == `SLS_OFS_ORG_ID ? {8'h0, org_id_q} :                   // RULE_19
        err01_rd ? {err_vld_q[1], err_cnt_q[1], err_vld_q[0], err_cnt_q[0]} :  // RULE_20
        err23_rd ? {err_vld_q[3], err_cnt_q[3], err_vld_q[2], err_cnt_q[2]} :  // RULE_20
        host_addr == `SLS_OFS_ATTR_FIRST ? {16'h0, attr_q.h_pixels} :       // RULE_21
        host_addr == `SLS_OFS_H_POL ? {31'h0, attr_q.h_sync_pol} :          // RULE_21
        host_addr == `SLS_OFS_H_WIDTH ? {17'h0, attr_q.h_sync_width} :      // RULE_21
        host_addr == `SLS_OFS_H_START ? {16'h0, attr_q.h_start} :           // RULE_21
        host_addr == `SLS_OFS_H_TOTAL ? {16'h0, attr_q.h_total} :           // RULE_21
        host_addr == `SLS_OFS_V_LINES ? {16'h0, attr_q.v_lines} :           // RULE_22
        host_addr == `SLS_OFS_V_POL ? {31'h0, attr_q.v_sync_pol} :          // RULE_22
        host_addr == `SLS_OFS_V_WIDTH ? {17'h0, attr_q.v_sync_width} :      // RULE_22
        host_addr == `SLS_OFS_V_START ? {16'h0, attr_q.v_start} :           // RULE_22
        host_addr == `SLS_OFS_ATTR_LAST ? {16'h0, attr_q.v_total} : 32'h0;

    // ------------------------------------------------------------------
    // Audio packet capture and read tracking
    // ------------------------------------------------------------------

    // Packet memories hold no control state and need no reset
    always_ff @(posedge clk) begin
        if (info_take) begin
            info_mem[info_wr_q[2:0]] <= pkt_word.word;
        end
        if (ext_take) begin
            ext_mem[ext_wr_q] <= pkt_word.word;  // RULE_05
        end
    end

    // Flags set when a whole packet is stored, cleared after the last read
    always_ff @(posedge clk) begin
        if (reset) begin
            info_wr_q <= 4'h0;
            ext_wr_q <= 4'h0;
            info_rd_q <= 4'h0;
            ext_rd_q <= 4'h0;
            info_flag_q <= 1'b0;
            ext_flag_q <= 1'b0;
            rs_cnt_q <= 2'h0;
        end else begin
            // Info words land only while no packet waits
            info_wr_q <= info_done ? 4'h0 : info_take ? info_wr_q + 4'h1 : info_wr_q;  // RULE_02
            // Extension length fixed at nine words
            ext_wr_q <= ext_done ? 4'h0 : ext_take ? ext_wr_q + 4'h1 : ext_wr_q;  // RULE_04
            // Read counts advance only while a packet waits
            info_rd_q <= info_read_out ? 4'h0 :
                         (info_rd && info_flag_q) ? info_rd_q + 4'h1 : info_rd_q;
            ext_rd_q <= ext_read_out ? 4'h0 :
                        (ext_rd && ext_flag_q) ? ext_rd_q + 4'h1 : ext_rd_q;  // RULE_05
            info_flag_q <= info_done | (info_flag_q & ~info_read_out);  // RULE_02
            ext_flag_q <= ext_done | (ext_flag_q & ~ext_read_out);  // RULE_01
            rs_cnt_q <= rs_cnt_q + {1'b0, rs_err};  // RULE_03
        end
    end

    // ------------------------------------------------------------------
    // Configuration mirrors
    // ------------------------------------------------------------------

    // Each mirror takes its value on its own write and holds otherwise
    always_ff @(posedge clk) begin
        if (reset) begin
            rate_q <= `SLS_RST_LINK_RATE;
            lanes_q <= 5'h0;
            framing_q <= 1'b0;
            training_q <= 2'h0;
            quality_q <= 2'h0;
            rec_clk_q <= 1'b0;
            scram_off_q <= 1'b0;
            err_src_q <= 2'h0;
            drive_q <= '{default: 6'h0};
            spread_q <= 1'b0;
            coding_q <= `SLS_RST_CODING;  // RULE_16
            power_q <= `SLS_RST_POWER;  // RULE_17
            org_id_q <= 24'h0;
        end else if (cfg_wr.valid) begin  // RULE_23
            case (cfg_wr.sel)
                sls_pkg::SLS_CFG_RATE: rate_q <= cfg_wr.data[7:0];  // RULE_06
                sls_pkg::SLS_CFG_LANES: lanes_q <= cfg_wr.data[4:0];  // RULE_07
                sls_pkg::SLS_CFG_FRAMING: framing_q <= cfg_wr.data[0];  // RULE_08
                sls_pkg::SLS_CFG_TRAINING: training_q <= cfg_wr.data[1:0];  // RULE_09
                sls_pkg::SLS_CFG_QUALITY: quality_q <= cfg_wr.data[1:0];  // RULE_10
                sls_pkg::SLS_CFG_REC_CLOCK: rec_clk_q <= cfg_wr.data[0];  // RULE_11
                sls_pkg::SLS_CFG_SCRAMBLER: scram_off_q <= cfg_wr.data[0];  // RULE_12
                sls_pkg::SLS_CFG_ERR_SOURCE: err_src_q <= cfg_wr.data[1:0];  // RULE_13
                sls_pkg::SLS_CFG_DRIVE0: drive_q[0] <= cfg_wr.data[5:0];  // RULE_14
                sls_pkg::SLS_CFG_DRIVE1: drive_q[1] <= cfg_wr.data[5:0];  // RULE_14
                sls_pkg::SLS_CFG_DRIVE2: drive_q[2] <= cfg_wr.data[5:0];  // RULE_14
                sls_pkg::SLS_CFG_DRIVE3: drive_q[3] <= cfg_wr.data[5:0];  // RULE_14
                sls_pkg::SLS_CFG_SPREAD: spread_q <= cfg_wr.data[0];  // RULE_15
                sls_pkg::SLS_CFG_CODING: coding_q <= cfg_wr.data[0];  // RULE_16
                sls_pkg::SLS_CFG_POWER: power_q <= cfg_wr.data[1:0];  // RULE_17
                sls_pkg::SLS_CFG_ORG_ID: org_id_q <= cfg_wr.data;  // RULE_19
                default: rate_q <= rate_q;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Lane status, error counters and stream attributes
    // ------------------------------------------------------------------

    // Counts saturate; a valid flag set in a read cycle survives the read
    always_ff @(posedge clk) begin
        if (reset) begin
            train_q <= '0;
            err_cnt_q <= '{default: 15'h0};
            err_vld_q <= 4'h0;
            attr_q <= '0;
        end else begin
            train_q <= lane_train;  // RULE_18
            for (int i = 0; i < 4; i++) begin
                err_cnt_q[i] <= err_inc(err_cnt_q[i], err_hit_v[i]);  // RULE_20
            end
            err_vld_q <= err_hit_v | (err_vld_q & ~err_clr_v);  // RULE_20
            if (attr.valid) begin
                attr_q <= attr;  // RULE_23
            end
        end
    end

    // ------------------------------------------------------------------
    // Host read answer and outputs
    // ------------------------------------------------------------------

    // Answer one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 32'h0;
            rvalid_q <= 1'b0;
            info_ready_q <= 1'b0;
            ext_ready_q <= 1'b0;
        end else begin
            rdata_q <= host_rd ? rd_mux : 32'h0;
            rvalid_q <= host_rd;
            info_ready_q <= ~(info_done | (info_flag_q & ~info_read_out));  // RULE_02
            ext_ready_q <= ~(ext_done | (ext_flag_q & ~ext_read_out));  // RULE_01
        end
    end

    assign host_rdata = rdata_q;
    assign host_rvalid = rvalid_q;
    assign info_ready = info_ready_q;
    assign ext_ready = ext_ready_q;
    assign rec_clk_out_en = rec_clk_q;  // RULE_11
    assign power_state = power_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_ext_clear;
        @(posedge clk) disable iff (reset) ext_read_out |=> !ext_flag_q ##1 ext_ready;
    endproperty
    a_ext_clear: assert property (p_ext_clear) else $error("ext flag not cleared");  // RULE_01

    property p_ext_hold;
        @(posedge clk) disable iff (reset) ext_flag_q && !ext_read_out |=> $stable(ext_wr_q);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("ext packet not blocked");  // RULE_01

    property p_info_clear;
        @(posedge clk) disable iff (reset) info_read_out |=> !info_flag_q ##1 info_ready;
    endproperty
    a_info_clear: assert property (p_info_clear) else $error("info flag not cleared");  // RULE_02

    property p_info_set;
        @(posedge clk) disable iff (reset) info_done |=> info_flag_q ##1 !info_ready;
    endproperty
    a_info_set: assert property (p_info_set) else $error("info flag not set");  // RULE_02

    property p_status_rsvd;
        @(posedge clk) disable iff (reset)
            host_rd && host_addr == `SLS_OFS_AUDIO_STATUS |=> host_rdata[8:3] == 6'h0
            && host_rdata[0] == $past(info_flag_q);
    endproperty
    a_status_rsvd: assert property (p_status_rsvd) else $error("status bits wrong");  // RULE_03

    property p_rate_mirror;
        @(posedge clk) disable iff (reset)
            cfg_wr.valid && cfg_wr.sel == sls_pkg::SLS_CFG_RATE ##1 !cfg_wr.valid ##1 host_rd
            && host_addr == `SLS_OFS_LINK_RATE |=> host_rdata == {24'h0, $past(cfg_wr.data[7:0], 3)};
    endproperty
    a_rate_mirror: assert property (p_rate_mirror) else $error("rate mirror wrong");  // RULE_06

    property p_rec_clk;
        @(posedge clk) disable iff (reset)
            cfg_wr.valid && cfg_wr.sel == sls_pkg::SLS_CFG_REC_CLOCK |=> rec_clk_out_en == $past(cfg_wr.data[0]);
    endproperty
    a_rec_clk: assert property (p_rec_clk) else $error("clock enable wrong");  // RULE_11

    property p_reset_vals;
        @(posedge clk) $fell(reset) |-> power_state == 2'h2 && coding_q && !info_flag_q;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");  // RULE_17

    property p_err_valid;
        @(posedge clk) disable iff (reset)
            err01_rd && err_hit_v[1:0] == 2'h0 |=> err_vld_q[1:0] == 2'h0;
    endproperty
    a_err_valid: assert property (p_err_valid) else $error("valid not cleared");  // RULE_20

    property p_attr_hold;
        @(posedge clk) disable iff (reset) !attr.valid |=> $stable(attr_q);
    endproperty
    a_attr_hold: assert property (p_attr_hold) else $error("attributes changed");  // RULE_23

    c_info_cycle: cover property (@(posedge clk) info_done ##[1:40] info_read_out);
    c_ext_cycle: cover property (@(posedge clk) ext_done ##[1:40] ext_read_out);
    c_err_read: cover property (@(posedge clk) err_vld_q[0] ##1 err01_rd);

endmodule

// ===== sls_map.svh
/*
 * Register offsets, field positions, reset values and sizes of the sink
 * link status register bank.
 * Assumes byte addresses on a 12-bit host read port, one word per register.
 */
`ifndef SLS_MAP_SVH
`define SLS_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SLS_OFS_INFO_FIRST 12'h304
`define SLS_OFS_INFO_LAST 12'h320
`define SLS_OFS_AUDIO_STATUS 12'h32C
`define SLS_OFS_EXT_FIRST 12'h330
`define SLS_OFS_EXT_LAST 12'h350
`define SLS_OFS_LINK_RATE 12'h400
`define SLS_OFS_LANE_TOTAL 12'h404
`define SLS_OFS_FRAMING 12'h408
`define SLS_OFS_TRAINING 12'h40C
`define SLS_OFS_QUALITY 12'h410
`define SLS_OFS_REC_CLOCK 12'h414
`define SLS_OFS_SCRAMBLER_OFF 12'h418
`define SLS_OFS_ERR_SOURCE 12'h41C
`define SLS_OFS_DRIVE_LANE0 12'h420
`define SLS_OFS_DRIVE_LANE3 12'h42C
`define SLS_OFS_SPREAD 12'h430
`define SLS_OFS_CODING 12'h434
`define SLS_OFS_POWER 12'h438
`define SLS_OFS_STATUS01 12'h43C
`define SLS_OFS_STATUS23 12'h440
`define SLS_OFS_ORG_ID 12'h444
`define SLS_OFS_ERR01 12'h448
`define SLS_OFS_ERR23 12'h44C
`define SLS_OFS_ATTR_FIRST 12'h500
`define SLS_OFS_H_POL 12'h504
`define SLS_OFS_H_WIDTH 12'h508
`define SLS_OFS_H_START 12'h50C
`define SLS_OFS_H_TOTAL 12'h510
`define SLS_OFS_V_LINES 12'h514
`define SLS_OFS_V_POL 12'h518
`define SLS_OFS_V_WIDTH 12'h51C
`define SLS_OFS_V_START 12'h520
`define SLS_OFS_ATTR_LAST 12'h524

// ----------------------------------------------------------------------
// Fields, reset values and sizes
// ----------------------------------------------------------------------
`define SLS_BIT_INFO_FLAG 0
`define SLS_BIT_EXT_FLAG 9
`define SLS_RST_LINK_RATE 8'h06
`define SLS_RST_CODING 1'b1
`define SLS_RST_POWER 2'h2
`define SLS_INFO_WORDS 4'h8
`define SLS_EXT_WORDS 4'h9
`define SLS_ERR_MAX 15'h7FFF

`endif

// ===== sls_pkg.sv
/*
 * Types shared by the sink link status register bank.
 * Assumes sls_map.svh carries the numeric constants.
 */
package sls_pkg;

    // Configuration value written by the transmitter over the aux channel
    typedef enum logic [3:0] {
        SLS_CFG_RATE, SLS_CFG_LANES, SLS_CFG_FRAMING, SLS_CFG_TRAINING,
        SLS_CFG_QUALITY, SLS_CFG_REC_CLOCK, SLS_CFG_SCRAMBLER, SLS_CFG_ERR_SOURCE,
        SLS_CFG_DRIVE0, SLS_CFG_DRIVE1, SLS_CFG_DRIVE2, SLS_CFG_DRIVE3,
        SLS_CFG_SPREAD, SLS_CFG_CODING, SLS_CFG_POWER, SLS_CFG_ORG_ID
    } sls_cfg_sel_type;

    // One configuration write
    typedef struct packed {
        logic valid;
        sls_cfg_sel_type sel;
        logic [23:0] data;
    } sls_cfg_wr_type;

    // One word of an audio info or extension packet
    typedef struct packed {
        logic valid;
        logic is_ext;
        logic [31:0] word;
    } sls_pkt_word_type;

    // Decoded stream attributes, one update per attribute packet
    typedef struct packed {
        logic valid;
        logic [15:0] h_pixels;
        logic h_sync_pol;
        logic [14:0] h_sync_width;
        logic [15:0] h_start;
        logic [15:0] h_total;
        logic [15:0] v_lines;
        logic v_sync_pol;
        logic [14:0] v_sync_width;
        logic [15:0] v_start;
        logic [15:0] v_total;
    } sls_attr_type;

endpackage

// ===== sls_tx_model.sv
/* Transmitter-side model: config writes, packet words, stream attributes.
   Assumes its tasks are called 1 ns after a clk edge. */
`timescale 1ns/1ps
module sls_tx_model (
    // Clock
    input wire logic clk,
    // Link-layer drive
    output sls_pkg::sls_cfg_wr_type cfg_wr,
    output sls_pkg::sls_pkt_word_type pkt_word,
    output sls_pkg::sls_attr_type attr
);
    // Idle at time zero
    initial begin
        cfg_wr = '0;
        pkt_word = '0;
        attr = '0;
    end
    // One write pulse; data inverted once released
    task send_cfg(input logic [3:0] s, input logic [23:0] x);
        cfg_wr = {1'b1, s, x};
        @(posedge clk) #1 cfg_wr = {1'b0, s, ~x};
    endtask
    // Whole packet, header word first
    task send_pkt(input logic x, input logic [31:0] b);
        for (int i = 0; i < (x ? 9 : 8); i++) begin
            pkt_word = {1'b1, x, b + 32'(i)};
            @(posedge clk) #1;
        end
        pkt_word = {1'b0, x, ~b};
    endtask
    // One attribute set
    task send_attr(input sls_pkg::sls_attr_type x);
        attr = {1'b1, x[127:0]};
        @(posedge clk) #1 attr = {1'b0, ~x[127:0]};
    endtask
endmodule

// ===== tb.sv
/* Self-checking bench for the status bank.
   Assumes sls_tx_model plays the transmitter. */
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // Signals and scoreboard state
    // ------------------------------------------------------------
    logic clk = 0, reset = 1, host_rd = 0, rs_err = 0, host_rvalid;
    logic info_ready, ext_ready, rec_clk_out_en;
    logic [1:0] power_state;
    logic [11:0] host_addr = '0, lane_train = '0;
    logic [3:0] lane_disp_err = '0, lane_sym_err = '0;
    logic [31:0] host_rdata, d, b, e[10], q[$];
    logic [159:0] r;
    sls_pkg::sls_cfg_wr_type cfg_wr;
    sls_pkg::sls_pkt_word_type pkt_word;
    sls_pkg::sls_attr_type attr, a;
    int n_mismatch = 0, checked = 0, v;
    sls_tx_model tx (.clk(clk), .cfg_wr(cfg_wr), .pkt_word(pkt_word), .attr(attr));
    sls_status_bank dut (.clk(clk), .reset(reset), .host_rd(host_rd), .host_addr(host_addr),
        .host_rdata(host_rdata), .host_rvalid(host_rvalid), .cfg_wr(cfg_wr),
        .pkt_word(pkt_word), .attr(attr), .rs_err(rs_err), .lane_disp_err(lane_disp_err),
        .lane_sym_err(lane_sym_err), .lane_train(lane_train), .info_ready(info_ready),
        .ext_ready(ext_ready), .rec_clk_out_en(rec_clk_out_en), .power_state(power_state));
    // 40 MHz clock
    initial forever #12.5 clk = ~clk;
    // Compare and count
    task chk(input logic [31:0] s, input logic [31:0] x);
        checked++;
        if (s !== x) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    // Host read, bounded wait for the answer
    task rc(input logic [11:0] ad, input logic [31:0] x);
        @(posedge clk) #1 host_rd = 1;
        host_addr = ad;
        @(posedge clk) #1 host_rd = 0;
        host_addr = ~ad;
        chk(32'(host_rvalid), 1);
        for (int i = 0; i < 4 && host_rvalid !== 1'b1; i++) @(posedge clk) #1;
        d = host_rdata;
        chk(d, x);
    endtask
    // Error pulse pair {symbol, disparity}
    task pulse(input logic [7:0] p);
        @(posedge clk) #1 {lane_sym_err, lane_disp_err} = p;
        @(posedge clk) #1 {lane_sym_err, lane_disp_err} = 8'h00;
    endtask
    // Legal value per config kind
    function automatic int pick(int s);
        case (s)
            0: return 32'h0A;
            1: return 1 + $urandom % 4;
            3, 7: return $urandom % 3;
            4: return $urandom % 4;
            8, 9, 10, 11: return $urandom % 64;
            14: return 1 + $urandom % 2;
            15: return $urandom % 32'h1000000;
            default: return $urandom % 2;
        endcase
    endfunction
    // Verdict
    task stop_test;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Watchdog
    initial begin
        #100us;
        n_mismatch++;
        stop_test;
    end
    // Main sequence
    initial begin
        v = $urandom(32'h9281D1F2);
        repeat (8) @(posedge clk);
        #1 reset = 0;
        rc(12'h400, 32'h06);
        rc(12'h434, 32'h01);
        rc(12'h438, 32'h02);
        for (int s = 0; s < 16; s++) begin
            v = pick(s);
            tx.send_cfg(s[3:0], v[23:0]);
            rc(s == 15 ? 12'h444 : 12'h400 + 12'(s * 4), v);
            if (s == 5) chk(32'(rec_clk_out_en), v);
            if (s == 14) chk(32'(power_state), v);
        end
        b = $urandom;
        tx.send_pkt(1, b);
        repeat (2) @(posedge clk);
        #1 chk(32'(ext_ready), 0);
        tx.send_pkt(1, ~b);
        rc(12'h32C, 32'h200);
        for (int i = 0; i < 9; i++) q.push_back(b + 32'(i));
        for (int i = 0; i < 9; i++) rc(12'h330 + 12'(i * 4), q.pop_front());
        rc(12'h32C, 0);
        chk(32'(ext_ready), 1);
        tx.send_pkt(0, b);
        repeat (2) @(posedge clk);
        #1 chk(32'(info_ready), 0);
        rc(12'h32C, 32'h1);
        for (int i = 0; i < 8; i++) q.push_back(b + 32'(i));
        for (int i = 0; i < 8; i++) rc(12'h304 + 12'(i * 4), q.pop_front());
        rc(12'h32C, 0);
        chk(32'(info_ready), 1);
        repeat (3) begin
            @(posedge clk) #1 rs_err = 1;
            @(posedge clk) #1 rs_err = 0;
        end
        rc(12'h32C, 32'h6);
        tx.send_cfg(7, 0);
        for (int i = 0; i < 4; i++) pulse(i < 2 ? 8'h20 : 8'h02);
        rc(12'h448, 32'h80040000);
        rc(12'h448, 32'h00040000);
        tx.send_cfg(7, 1);
        pulse(8'h40);
        pulse(8'h08);
        rc(12'h44C, 32'h80010000);
        lane_train = 12'($urandom);
        rc(12'h43C, 32'({lane_train[5:3], 1'b0, lane_train[2:0]}));
        rc(12'h440, 32'({lane_train[11:9], 1'b0, lane_train[8:6]}));
        r = {$urandom, $urandom, $urandom, $urandom, $urandom};
        a = r[128:0];
        tx.send_attr(a);
        e = '{a.h_pixels, a.h_sync_pol, a.h_sync_width, a.h_start, a.h_total,
              a.v_lines, a.v_sync_pol, a.v_sync_width, a.v_start, a.v_total};
        for (int i = 0; i < 10; i++) rc(12'h500 + 12'(i * 4), e[i]);
        rc(12'h600, 0);
        stop_test;
    end
endmodule
